//--- hdl/tmr_pkg.sv
// package for the target-mode receive configuration register bank
// assumes an axi4-lite host with 32-bit data; registers sit in byte lane 0
package tmr_pkg;

    // =====================================================================
    // register indices (byte address is four times the index)
    localparam logic [5:0] IDX_PKT_MAX_ANTICOLL = 6'h1b;
    localparam logic [5:0] IDX_CARD_MODE_MILLER = 6'h1c;
    localparam logic [5:0] IDX_RCV_MANUAL_TUNE  = 6'h1d;

    // =====================================================================
    // reset values and write masks
    localparam logic [7:0] RST_PKT_MAX_ANTICOLL = 8'h00;
    localparam logic [7:0] RST_CARD_MODE_MILLER = 8'h62;
    localparam logic [7:0] RST_RCV_MANUAL_TUNE  = 8'h00;
    localparam logic [7:0] WMASK_RCV_MANUAL     = 8'h7f;

    // =====================================================================
    // field positions
    localparam int WAIT_SEL_BIT   = 7;
    localparam int SHORT_SLOT_BIT = 6;
    localparam int MAXLEN_MSB     = 5;
    localparam int MAXLEN_LSB     = 0;
    localparam int SENS_MSB       = 7;
    localparam int SENS_LSB       = 5;
    localparam int TAU_MSB        = 4;
    localparam int TAU_LSB        = 3;
    localparam int HALT_BIT       = 2;
    localparam int RWAIT_MSB      = 1;
    localparam int RWAIT_LSB      = 0;
    localparam int FAST_FILT_BIT  = 6;
    localparam int SIGOUT_DLY_BIT = 5;
    localparam int PARITY_OFF_BIT = 4;
    localparam int WIDE_PLL_BIT   = 3;
    localparam int MAN_HP_BIT     = 2;
    localparam int HPC_MSB        = 1;
    localparam int HPC_LSB        = 0;

    // =====================================================================
    // protocol constants
    typedef enum logic [1:0] {
        RATE_106 = 2'h0,
        RATE_212 = 2'h1,
        RATE_424 = 2'h2,
        RATE_848 = 2'h3
    } tmr_rate_type;

    localparam logic [7:0] REQ_CODE_HALTED = 8'h52;
    localparam logic [3:0] RESP_FIXED_BITS = 4'h7;
    localparam logic [8:0] LEN_ZERO_MAX    = 9'h100;
    localparam logic [8:0] LEN_SATURATE    = 9'h1ff;
    localparam logic [1:0] AXI_OKAY        = 2'h0;
    localparam logic [1:0] AXI_SLVERR      = 2'h2;

endpackage

//--- hdl/tmr_regs.sv
// register bank and receive-path qualifiers for target / card-emulation mode
// assumes receive-path strobes arrive from logic on SYS_CLK; host uses axi4-lite
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - with wait_for_selected_a set, anticollision ends only after select/poll then command
// - wait_for_selected_a set forbids active communication mode
// - 424 kbit passive slot is half the 212 slot when short_time_slot_b set
// - packet accepted only if length is at most four times max_packet_len
// - max_packet_len of zero means 256 bytes limit
// - at 106 kbit without sync_detect_enable the length limit is ignored
// - packets longer than the limit are dropped silently
// - card_halted bit two reads one while card is halted at 106 kbit
// - while halted only request code 52h is accepted
// - host writes and internal state machine can both set card_halted
// - an rf field reset clears card_halted
// - response_wait bits one to zero add target response time at 106 kbit
// - seven bit durations are added to response_wait
// - miller_sensitivity bits seven to five tune the miller decoder
// - miller_time_const bits four to three set the miller time constant
// - parity_off disables parity generation and checking; parity becomes data
// - manual_highpass zero adapts the corner; one applies highpass_corner
module tmr_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic              SYS_CLK,
    input  wire logic              NRST,
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    output logic [1:0]             BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    input  wire logic [ADDR_W-1:0] ARADDR,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    output logic [31:0]            RDATA,
    output logic [1:0]             RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY,
    input  wire logic [1:0]        RX_RATE,
    input  wire logic              PASSIVE_MODE,
    input  wire logic              SYNC_DETECT_ENABLE,
    input  wire logic              RX_BYTE_STB,
    input  wire logic              RX_END,
    input  wire logic              REQ_VALID,
    input  wire logic [7:0]        REQ_CODE,
    input  wire logic              HALT_SET,
    input  wire logic              RF_RESET,
    input  wire logic              AUTO_ANTICOLLISION_CMD_ACTIVE,
    input  wire logic              SELECT_DONE,
    input  wire logic              CMD_VALID,
    output logic                   PKT_ACCEPT,
    output logic                   PKT_DROP,
    output logic                   REQ_ACCEPT,
    output logic                   AUTO_ANTICOLLISION_CMD_DONE,
    output logic                   ACTIVE_MODE_ALLOWED,
    output logic                   TIME_SLOT_HALF,
    output logic [3:0]             RESP_WAIT_BITS,
    output logic [2:0]             MILLER_SENSITIVITY,
    output logic [1:0]             MILLER_TIME_CONST,
    output logic                   CARD_HALTED,
    output logic                   PARITY_OFF,
    output logic [1:0]             HIGHPASS_CORNER,
    output logic                   FAST_DELAY_FILTER,
    output logic                   SIGNAL_OUT_DELAY,
    output logic                   WIDE_PLL_BANDWIDTH
);

    if (ADDR_W < 8 || ADDR_W > 16) begin : g_addr_w_check
        $error("ADDR_W must lie between 8 and 16");
    end

    // =====================================================================
    // reset release synchroniser
    logic rst_meta_ff;
    logic rst_n;
    default clocking cb_sys @(posedge SYS_CLK);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    // =====================================================================
    // state
    typedef struct packed {
        logic              aw_hold;
        logic [ADDR_W-1:0] aw_addr;
        logic              aw_rdy;
        logic              w_hold;
        logic [7:0]        w_data;
        logic              w_lane0;
        logic              w_rdy;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              ar_rdy;
        logic              rvalid;
        logic [7:0]        rdata;
        logic [1:0]        rresp;
        logic [7:0]        reg_pkt;
        logic [7:0]        reg_card;
        logic [7:0]        reg_rcv;
        logic [8:0]        rx_cnt;
        logic              selected;
        logic              pkt_acc;
        logic              pkt_drop;
        logic              req_acc;
        logic              ac_done;
        logic              active_ok;
        logic              slot_half;
        logic [3:0]        resp_bits;
        logic [1:0]        hp_corner;
    } tmr_state_type;

    tmr_state_type s_ff;
    tmr_state_type nxt_s;

    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic       wr_go;
    logic       wr_card;
    logic [8:0] rx_len;
    logic [8:0] len_limit;
    logic       len_check;
    logic       len_over;
    logic [5:0] max_len;

    assign wr_idx  = s_ff.aw_addr[7:2];
    assign rd_idx  = ARADDR[7:2];
    assign wr_go   = s_ff.aw_hold && s_ff.w_hold && !s_ff.bvalid;
    assign wr_card = wr_go && s_ff.w_lane0 && (wr_idx == tmr_pkg::IDX_CARD_MODE_MILLER);
    assign max_len = s_ff.reg_pkt[tmr_pkg::MAXLEN_MSB:tmr_pkg::MAXLEN_LSB];
    // byte in the same cycle as the end marker still counts
    assign rx_len  = (RX_BYTE_STB && s_ff.rx_cnt != tmr_pkg::LEN_SATURATE) ?
                     s_ff.rx_cnt + 9'h001 : s_ff.rx_cnt;
    assign len_limit = (max_len == 6'h00) ? tmr_pkg::LEN_ZERO_MAX :
                       {1'b0, max_len, 2'b00};
    assign len_check = !(RX_RATE == tmr_pkg::RATE_106 && !SYNC_DETECT_ENABLE);
    assign len_over  = len_check && rx_len > len_limit;

    // =====================================================================
    // next state
    always_comb begin
        nxt_s = s_ff;

        // write address and data are taken independently, in either order
        if (AWVALID && s_ff.aw_rdy) begin
            nxt_s.aw_hold = 1'b1;
            nxt_s.aw_addr = AWADDR;
        end
        if (WVALID && s_ff.w_rdy) begin
            nxt_s.w_hold  = 1'b1;
            nxt_s.w_data  = WDATA[7:0];
            nxt_s.w_lane0 = WSTRB[0];
        end
        if (s_ff.bvalid && BREADY) begin
            nxt_s.bvalid = 1'b0;
        end

        // hardware events on the halted flag; host write below, hw set last
        if (RF_RESET) begin
            nxt_s.reg_card[tmr_pkg::HALT_BIT] = 1'b0;
        end

        if (wr_go) begin
            nxt_s.aw_hold = 1'b0;
            nxt_s.w_hold  = 1'b0;
            nxt_s.bvalid  = 1'b1;
            nxt_s.bresp   = tmr_pkg::AXI_OKAY;
            case (wr_idx)
                tmr_pkg::IDX_PKT_MAX_ANTICOLL: begin
                    if (s_ff.w_lane0) begin
                        nxt_s.reg_pkt = s_ff.w_data;
                    end
                end
                tmr_pkg::IDX_CARD_MODE_MILLER: begin
                    if (s_ff.w_lane0) begin
                        nxt_s.reg_card = s_ff.w_data;
                    end
                end
                tmr_pkg::IDX_RCV_MANUAL_TUNE: begin
                    // bit 7 is reserved and always reads zero
                    if (s_ff.w_lane0) begin
                        nxt_s.reg_rcv = s_ff.w_data & tmr_pkg::WMASK_RCV_MANUAL;
                    end
                end
                default: begin
                    nxt_s.bresp = tmr_pkg::AXI_SLVERR;
                end
            endcase
        end

        // set wins over the rf reset clear and over a host write of zero
        if (HALT_SET) begin
            nxt_s.reg_card[tmr_pkg::HALT_BIT] = 1'b1;
        end

        // read channel
        if (s_ff.rvalid && RREADY) begin
            nxt_s.rvalid = 1'b0;
        end
        if (ARVALID && s_ff.ar_rdy) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp  = tmr_pkg::AXI_OKAY;
            case (rd_idx)
                tmr_pkg::IDX_PKT_MAX_ANTICOLL: nxt_s.rdata = s_ff.reg_pkt;
                tmr_pkg::IDX_CARD_MODE_MILLER: nxt_s.rdata = s_ff.reg_card;
                tmr_pkg::IDX_RCV_MANUAL_TUNE:  nxt_s.rdata = s_ff.reg_rcv;
                default: begin
                    nxt_s.rdata = 8'h00;
                    nxt_s.rresp = tmr_pkg::AXI_SLVERR;
                end
            endcase
        end

        // ready is offered only while the holding slot is free
        nxt_s.aw_rdy = !nxt_s.aw_hold;
        nxt_s.w_rdy  = !nxt_s.w_hold;
        nxt_s.ar_rdy = !nxt_s.rvalid;

        // packet length qualification; an rf reset abandons the packet under way
        nxt_s.rx_cnt   = (RX_END || RF_RESET) ? 9'h000 : rx_len;
        nxt_s.pkt_drop = RX_END && len_over;
        nxt_s.pkt_acc  = RX_END && !len_over;

        // request filter while halted
        nxt_s.req_acc = REQ_VALID &&
                        (!s_ff.reg_card[tmr_pkg::HALT_BIT] ||
                         REQ_CODE == tmr_pkg::REQ_CODE_HALTED);

        // anticollision termination
        nxt_s.ac_done = 1'b0;
        if (AUTO_ANTICOLLISION_CMD_ACTIVE && CMD_VALID &&
            (!s_ff.reg_pkt[tmr_pkg::WAIT_SEL_BIT] || s_ff.selected)) begin
            nxt_s.ac_done = 1'b1;
        end
        if (RF_RESET || nxt_s.ac_done || !AUTO_ANTICOLLISION_CMD_ACTIVE) begin
            nxt_s.selected = 1'b0;
        end else if (SELECT_DONE) begin
            nxt_s.selected = 1'b1;
        end

        nxt_s.active_ok = !s_ff.reg_pkt[tmr_pkg::WAIT_SEL_BIT];
        nxt_s.slot_half = PASSIVE_MODE && RX_RATE == tmr_pkg::RATE_424 &&
                          s_ff.reg_pkt[tmr_pkg::SHORT_SLOT_BIT];
        // extra response time in bit durations at 106 kbit
        nxt_s.resp_bits = tmr_pkg::RESP_FIXED_BITS +
                          {2'b00, s_ff.reg_card[tmr_pkg::RWAIT_MSB:tmr_pkg::RWAIT_LSB]};
        // without manual override the corner follows the receive rate
        nxt_s.hp_corner = s_ff.reg_rcv[tmr_pkg::MAN_HP_BIT] ?
                          s_ff.reg_rcv[tmr_pkg::HPC_MSB:tmr_pkg::HPC_LSB] : RX_RATE;
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_ff          <= '0;
            s_ff.aw_rdy   <= 1'b1;
            s_ff.w_rdy    <= 1'b1;
            s_ff.ar_rdy   <= 1'b1;
            s_ff.reg_pkt  <= tmr_pkg::RST_PKT_MAX_ANTICOLL;
            s_ff.reg_card <= tmr_pkg::RST_CARD_MODE_MILLER;
            s_ff.reg_rcv  <= tmr_pkg::RST_RCV_MANUAL_TUNE;
            s_ff.active_ok <= 1'b1;
            s_ff.resp_bits <= tmr_pkg::RESP_FIXED_BITS;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // =====================================================================
    // outputs
    assign AWREADY             = s_ff.aw_rdy;
    assign WREADY              = s_ff.w_rdy;
    assign BVALID              = s_ff.bvalid;
    assign BRESP               = s_ff.bresp;
    assign ARREADY             = s_ff.ar_rdy;
    assign RVALID              = s_ff.rvalid;
    assign RDATA               = {24'h000000, s_ff.rdata};
    assign RRESP               = s_ff.rresp;
    assign PKT_ACCEPT          = s_ff.pkt_acc;
    assign PKT_DROP            = s_ff.pkt_drop;
    assign REQ_ACCEPT          = s_ff.req_acc;
    assign AUTO_ANTICOLLISION_CMD_DONE       = s_ff.ac_done;
    assign ACTIVE_MODE_ALLOWED = s_ff.active_ok;
    assign TIME_SLOT_HALF      = s_ff.slot_half;
    assign RESP_WAIT_BITS      = s_ff.resp_bits;
    assign MILLER_SENSITIVITY  = s_ff.reg_card[tmr_pkg::SENS_MSB:tmr_pkg::SENS_LSB];
    assign MILLER_TIME_CONST   = s_ff.reg_card[tmr_pkg::TAU_MSB:tmr_pkg::TAU_LSB];
    assign CARD_HALTED         = s_ff.reg_card[tmr_pkg::HALT_BIT];
    assign PARITY_OFF          = s_ff.reg_rcv[tmr_pkg::PARITY_OFF_BIT];
    assign HIGHPASS_CORNER     = s_ff.hp_corner;
    assign FAST_DELAY_FILTER   = s_ff.reg_rcv[tmr_pkg::FAST_FILT_BIT];
    assign SIGNAL_OUT_DELAY    = s_ff.reg_rcv[tmr_pkg::SIGOUT_DLY_BIT];
    assign WIDE_PLL_BANDWIDTH  = s_ff.reg_rcv[tmr_pkg::WIDE_PLL_BIT];

    // =====================================================================
    // checks
    property p_drop_long;
        RX_END && len_check && rx_len > len_limit |=> PKT_DROP && !PKT_ACCEPT;
    endproperty
    a_drop_long: assert property (p_drop_long) else $error("long packet not dropped");
    property p_limit_ok;
        RX_END && max_len != 6'h00 && rx_len == {1'b0, max_len, 2'b00} |=> PKT_ACCEPT;
    endproperty
    a_limit_ok: assert property (p_limit_ok) else $error("packet at limit refused");
    property p_zero_256;
        RX_END && max_len == 6'h00 && rx_len == tmr_pkg::LEN_ZERO_MAX |=> PKT_ACCEPT;
    endproperty
    a_zero_256: assert property (p_zero_256) else $error("256 byte packet refused");
    property p_ignore_106;
        RX_END && RX_RATE == tmr_pkg::RATE_106 && !SYNC_DETECT_ENABLE |=> PKT_ACCEPT;
    endproperty
    a_ignore_106: assert property (p_ignore_106) else $error("limit applied at 106");
    property p_halt_req;
        REQ_VALID && CARD_HALTED && REQ_CODE != tmr_pkg::REQ_CODE_HALTED |=> !REQ_ACCEPT;
    endproperty
    a_halt_req: assert property (p_halt_req) else $error("request taken while halted");
    property p_hw_set;
        HALT_SET |=> CARD_HALTED;
    endproperty
    a_hw_set: assert property (p_hw_set) else $error("halt set lost");
    property p_rf_clear;
        RF_RESET && !HALT_SET && !wr_card |=> !CARD_HALTED;
    endproperty
    a_rf_clear: assert property (p_rf_clear) else $error("rf reset kept halt");
    property p_no_active;
        s_ff.reg_pkt[tmr_pkg::WAIT_SEL_BIT] [*2] |-> !ACTIVE_MODE_ALLOWED;
    endproperty
    a_no_active: assert property (p_no_active) else $error("active mode allowed");
    property p_ac_wait;
        s_ff.reg_pkt[tmr_pkg::WAIT_SEL_BIT] && !s_ff.selected |=> !AUTO_ANTICOLLISION_CMD_DONE;
    endproperty
    a_ac_wait: assert property (p_ac_wait) else $error("anticollision ended early");
    property p_resp_bits;
        $stable(s_ff.reg_card[1:0]) |=> RESP_WAIT_BITS == 4'h7 + {2'b00, $past(s_ff.reg_card[1:0])};
    endproperty
    a_resp_bits: assert property (p_resp_bits) else $error("response wait wrong");
    property p_slot;
        PASSIVE_MODE && RX_RATE == tmr_pkg::RATE_424 && s_ff.reg_pkt[6] |=> TIME_SLOT_HALF;
    endproperty
    a_slot: assert property (p_slot) else $error("short slot not used");
    property p_wr_resp;
        AWVALID && AWREADY && WVALID && WREADY |=> ##1 BVALID;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
    c_write:  cover property (BVALID && BREADY);
    c_read:   cover property (RVALID && RREADY);
    c_drop:   cover property (PKT_DROP);
    c_halted: cover property (CARD_HALTED && REQ_ACCEPT);

endmodule

`default_nettype wire

//--- tb/tmr_rf_peer.sv
// rf peer model: the reader or initiator across the field, sends frames and requests
// assumes the bench clock; every strobe changes just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module tmr_rf_peer (
    input  wire logic      clk,
    output var  logic      rx_byte_stb,
    output var  logic      rx_end,
    output var  logic      req_valid,
    output var  logic [7:0] req_code
);
    // ==================================================================
    // frames and requests
    initial begin
        rx_byte_stb = 1'b0;
        rx_end = 1'b0;
        req_valid = 1'b0;
        req_code = 8'h00;
    end

    // end strobe rides on the last byte, the awkward but legal case
    task automatic pkt(input int n);
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            rx_byte_stb <= 1'b1;
            rx_end <= (i == n);
        end
        @(posedge clk);
        rx_byte_stb <= 1'b0;
        rx_end <= 1'b0;
    endtask

    // code is not held past the strobe: show its inverse so stale data never matches
    task automatic req(input logic [7:0] c);
        @(posedge clk);
        req_valid <= 1'b1;
        req_code <= c;
        @(posedge clk);
        req_valid <= 1'b0;
        req_code <= ~c;
    endtask
endmodule
`default_nettype wire

//--- tb/target_mode_rx_config_regs_test.sv
// testbench for the target-mode receive configuration registers
// assumes tmr_regs with an 8-bit axi4-lite address and the rf peer model
`timescale 1ns/1ps
`default_nettype none
module target_mode_rx_config_regs_test;
    localparam logic [7:0] A_PKT = {tmr_pkg::IDX_PKT_MAX_ANTICOLL, 2'b00};
    localparam logic [7:0] A_MIL = {tmr_pkg::IDX_CARD_MODE_MILLER, 2'b00};
    localparam logic [7:0] A_RCV = {tmr_pkg::IDX_RCV_MANUAL_TUNE, 2'b00};
    localparam logic [1:0] ERR   = tmr_pkg::AXI_SLVERR;
    logic        clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, passive = 1'b1, sync_en = 1'b0, ac_active = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, req_code;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  evt = 4'h0, wstrb = 4'hf, resp_bits;
    logic [1:0]  rx_rate = 2'h2, bresp, rresp, tau, hpc;
    logic [2:0]  sens;
    logic        awready, wready, bvalid, arready, rvalid, rx_stb, rx_end, req_valid;
    logic        pkt_accept, pkt_drop, req_accept, ac_done, active_ok, slot_half, halted, par_off;
    logic        fast_filt, sig_dly, wide_pll;
    int          acc_n = 0, drop_n = 0, req_n = 0, done_n = 0, n_tests = 0, miscompares = 0;

    always #12.5 clk = ~clk;

    tmr_rf_peer peer_u (.clk(clk), .rx_byte_stb(rx_stb), .rx_end(rx_end),
        .req_valid(req_valid), .req_code(req_code));

    tmr_regs #(.ADDR_W(8)) dut_u (.SYS_CLK(clk), .NRST(nrst), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready), .RX_RATE(rx_rate), .PASSIVE_MODE(passive),
        .SYNC_DETECT_ENABLE(sync_en), .RX_BYTE_STB(rx_stb), .RX_END(rx_end),
        .REQ_VALID(req_valid), .REQ_CODE(req_code), .HALT_SET(evt[0]), .RF_RESET(evt[1]),
        .AUTO_ANTICOLLISION_CMD_ACTIVE(ac_active), .SELECT_DONE(evt[2]), .CMD_VALID(evt[3]),
        .PKT_ACCEPT(pkt_accept), .PKT_DROP(pkt_drop), .REQ_ACCEPT(req_accept),
        .AUTO_ANTICOLLISION_CMD_DONE(ac_done), .ACTIVE_MODE_ALLOWED(active_ok), .TIME_SLOT_HALF(slot_half),
        .RESP_WAIT_BITS(resp_bits), .MILLER_SENSITIVITY(sens), .MILLER_TIME_CONST(tau),
        .CARD_HALTED(halted), .PARITY_OFF(par_off), .HIGHPASS_CORNER(hpc),
        .FAST_DELAY_FILTER(fast_filt), .SIGNAL_OUT_DELAY(sig_dly), .WIDE_PLL_BANDWIDTH(wide_pll));

    // ==================================================================
    // pulse counters: one-cycle outputs are counted so a check never misses the cycle
    always @(posedge clk) begin
        if (pkt_accept === 1'b1) acc_n <= acc_n + 1;
        if (pkt_drop === 1'b1) drop_n <= drop_n + 1;
        if (req_accept === 1'b1) req_n <= req_n + 1;
        if (ac_done === 1'b1) done_n <= done_n + 1;
    end

    // ==================================================================
    // bus and check tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er = tmr_pkg::AXI_OKAY);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er = tmr_pkg::AXI_OKAY);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, exp);
        chk(32'(rresp), 32'(er));
    endtask

    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        evt <= m;
        @(posedge clk);
        evt <= 4'h0;
    endtask

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==================================================================
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #(25 * 20000);
        miscompares++;
        final_report();
    end

    // ==================================================================
    // test sequence
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        tick(3);
        rd(A_PKT, 32'h00);
        rd(A_MIL, 32'h62);
        rd(A_RCV, 32'h00);
        // a write without byte lane 0 is answered but changes nothing
        @(posedge clk) wstrb <= 4'he;
        wr(A_PKT, 8'h3f);
        rd(A_PKT, 32'h00);
        @(posedge clk) wstrb <= 4'hf;
        rd(8'h78, 32'h00, ERR);
        wr(8'h78, 8'h55, ERR);
        chk(32'(sens), 32'h3);
        chk(32'(resp_bits), 32'h9);
        wr(A_MIL, 8'hbb);
        tick(2);
        chk(32'(sens), 32'h5);
        chk(32'(tau), 32'h3);
        chk(32'(resp_bits), 32'ha);
        wr(A_MIL, 8'hbf);
        tick(2);
        chk(32'(halted), 32'h1);
        peer_u.req(8'h26);
        peer_u.req(8'h52);
        tick(2);
        chk(32'(req_n), 32'h1);
        pulse(4'h2);
        tick(2);
        chk(32'(halted), 32'h0);
        peer_u.req(8'h26);
        tick(2);
        chk(32'(req_n), 32'h2);
        pulse(4'h1);
        rd(A_MIL, 32'hbf);
        // length limit: four bytes per step, zero means the 256-byte ceiling
        wr(A_PKT, 8'h01);
        peer_u.pkt(4);
        peer_u.pkt(5);
        tick(2);
        chk(32'(acc_n), 32'h1);
        chk(32'(drop_n), 32'h1);
        wr(A_PKT, 8'h00);
        peer_u.pkt(256);
        peer_u.pkt(257);
        tick(2);
        chk(32'(acc_n), 32'h2);
        chk(32'(drop_n), 32'h2);
        wr(A_PKT, 8'h01);
        @(posedge clk) rx_rate <= 2'h0;
        peer_u.pkt(5);
        tick(2);
        chk(32'(acc_n), 32'h3);
        @(posedge clk) sync_en <= 1'b1;
        peer_u.pkt(5);
        tick(2);
        chk(32'(drop_n), 32'h3);
        @(posedge clk) rx_rate <= 2'h2;
        wr(A_PKT, 8'h40);
        tick(2);
        chk(32'(slot_half), 32'h1);
        @(posedge clk) passive <= 1'b0;
        tick(2);
        chk(32'(slot_half), 32'h0);
        @(posedge clk) passive <= 1'b1;
        wr(A_PKT, 8'h80);
        tick(2);
        chk(32'(slot_half), 32'h0);
        chk(32'(active_ok), 32'h0);
        @(posedge clk) ac_active <= 1'b1;
        pulse(4'h8);
        tick(2);
        chk(32'(done_n), 32'h0);
        pulse(4'h4);
        pulse(4'h8);
        tick(2);
        chk(32'(done_n), 32'h1);
        pulse(4'h8);
        tick(2);
        chk(32'(done_n), 32'h1);
        wr(A_PKT, 8'h00);
        tick(2);
        chk(32'(active_ok), 32'h1);
        pulse(4'h8);
        tick(2);
        chk(32'(done_n), 32'h2);
        wr(A_RCV, 8'hff);
        rd(A_RCV, 32'h7f);
        chk(32'(par_off), 32'h1);
        chk(32'({fast_filt, sig_dly, wide_pll}), 32'h7);
        chk(32'(hpc), 32'h3);
        wr(A_RCV, 8'h00);
        tick(2);
        chk(32'(hpc), 32'h2);
        chk(32'(par_off), 32'h0);
        chk(32'({fast_filt, sig_dly, wide_pll}), 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
